// File: src/pdm_pkg.sv
// Shared constants for the upper port and second port pin multiplexer
package pdm_pkg;
  // ****************************************
  // Register bus
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] REG_IF_MODE = 8'h00;
  localparam logic [7:0] REG_ALT_SEL = 8'h01;
  localparam logic [7:0] REG_POLARITY = 8'h02;
  localparam logic [7:0] REG_UP_PORT = 8'h03;
  localparam logic [7:0] REG_UP_DIR = 8'h04;
  localparam logic [7:0] REG_SE_PORT = 8'h05;
  localparam logic [7:0] REG_SE_DIR = 8'h06;
  localparam logic [7:0] REG_UP_PINS = 8'h07;
  localparam logic [7:0] REG_SE_PINS = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h09;
  localparam logic [7:0] REG_IRQ_CLR = 8'h0a;
  localparam logic [7:0] REG_IRQ_EN = 8'h0b;
  localparam logic [7:0] REG_T2_CTRL = 8'h0c;
  localparam logic [7:0] RST_VAL = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int IFM_WORD_BIT = 2;
  localparam int IFM_CLKINV_BIT = 3;
  localparam logic [1:0] MODE_WAVE = 2'h2;
  localparam logic [1:0] MODE_SLAVE = 2'h3;
  localparam int POL_RD_BIT = 3;
  localparam int POL_WR_BIT = 2;
  localparam int T2C_EXT_EN_BIT = 3;
  localparam logic [1:0] SER_SYNC_MODE = 2'h0;
  localparam int ALT_T0 = 0;
  localparam int ALT_T1 = 1;
  localparam int ALT_T2 = 2;
  localparam int ALT_SER0 = 3;
  localparam int ALT_SER1 = 4;
  localparam int ALT_EXT_IRQ_SIX_INPUT = 5;
  localparam int ALT_TIMER2_EXTERNAL_RELOAD = 6;
  localparam int ALT_ADR8 = 7;
  localparam logic [7:0] ALT_DRIVES = 8'h9f;
  localparam int IRQ_EXT_IRQ_SIX_INPUT = 0;
  localparam int IRQ_TIMER2_EXTERNAL_RELOAD = 1;
  localparam int IRQ_T2OVF = 2;
  localparam int IRQ_W = 3;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CPU_CLOCK_OUTPUT_DIV = 4;
endpackage : pdm_pkg

// File: src/pdm_ovf_if.sv
// Timer overflow event and its stretched pin pulse
`timescale 1ns/1ps
interface pdm_ovf_if;
  logic ovf;
  logic low_ovf;
  logic split;
  logic tick;
  logic pulse;
  modport src (output ovf, output low_ovf, output split, output tick, input pulse);
  modport gen (input ovf, input low_ovf, input split, input tick, output pulse);
endinterface : pdm_ovf_if

// File: src/pdm_ovf_pulse.sv
// Stretches a timer overflow to one cpu clock output cycle
`timescale 1ns/1ps
module pdm_ovf_pulse import pdm_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  pdm_ovf_if.gen ovf_io
);
  logic src_ev;
  logic pend_q;
  logic pend_d;
  logic pulse_q;

  assign src_ev = ovf_io.split ? ovf_io.low_ovf : ovf_io.ovf;
  assign pend_d = ~ovf_io.tick & (src_ev | pend_q);
  assign ovf_io.pulse = pulse_q;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pend_q <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      if (ovf_io.tick) begin
        pulse_q <= pend_q | src_ev;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_OVF_SRC: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (ovf_io.split && ovf_io.low_ovf) |=> (pend_q || pulse_q))
    else $error("low byte overflow lost in split mode");
  AST_OVF_HOLD: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (pulse_q && !ovf_io.tick) |=> (pulse_q == $past(pulse_q)))
    else $error("overflow pulse changed between ticks");
  AST_OVF_START: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    $changed(pulse_q) |-> $past(ovf_io.tick))
    else $error("overflow pulse changed off a tick");
endmodule : pdm_ovf_pulse

// File: src/pdm_pin_mux.sv
// Upper port and second port pin multiplexer with register file
//
// Contract
// - Upper port pins are port bits or upper data bus byte by mode and width
// - Each second port pin follows its own alternate select bit
// - Timer 0 and 1 overflow pins pulse high one cpu clock output cycle
// - In split timer mode the low byte overflow makes the pulse
// - Timer 2 overflow pin is high one clock on each overflow
// - Serial 0 pin carries data only in sync mode, else high
// - Serial 1 pin carries data in sync mode, high in modes one to three
// - Interrupt six input raises a request on a rising edge
// - Timer 2 input reloads on falling edge only with external enable set
// - Top second port pin carries waveform address bit eight
// - Ready pins zero and one are ready inputs or polarised slave strobes
// - Ready pin two is always a waveform engine input
// - Interface clock is the reference and may be inverted by a bit
`timescale 1ns/1ps
module pdm_pin_mux import pdm_pkg::*; #(
  parameter int W = 8,
  parameter int CLK_DIV = CPU_CLOCK_OUTPUT_DIV
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic irq_out,
  input wire logic [W-1:0] upper_port_bit_in,
  output logic [W-1:0] upper_port_bit_out,
  output logic [W-1:0] upper_port_bit_oe_n_out,
  input wire logic [W-1:0] second_port_bit_in,
  output logic [W-1:0] second_port_bit_out,
  output logic [W-1:0] second_port_bit_oe_n_out,
  input wire logic [W-1:0] parallel_data_bus_hi_in,
  input wire logic parallel_data_bus_drive_in,
  output logic [W-1:0] parallel_data_bus_hi_out,
  input wire logic timer0_ovf_in,
  input wire logic timer0_low_ovf_in,
  input wire logic timer0_split_in,
  input wire logic timer1_ovf_in,
  input wire logic timer1_low_ovf_in,
  input wire logic timer1_split_in,
  input wire logic timer2_ovf_in,
  input wire logic [1:0] serial0_mode_in,
  input wire logic serial0_data_in,
  input wire logic [1:0] serial1_mode_in,
  input wire logic serial1_data_in,
  input wire logic waveform_addr_bit8_in,
  output logic ext_irq_six_out,
  output logic timer2_external_reload_out,
  input wire logic ready_input_zero_in,
  input wire logic ready_input_one_in,
  input wire logic ready_input_two_in,
  output logic [2:0] waveform_ready_out,
  output logic slave_read_strobe_out,
  output logic slave_write_strobe_out,
  output logic interface_clock_invert_out,
  output logic cpu_clock_tick_out
);
  // ****************************************
  // Register decode
  // ****************************************
  logic [7:0] if_mode_q;
  logic [7:0] alt_sel_q;
  logic [7:0] pol_q;
  logic [W-1:0] up_port_q;
  logic [W-1:0] up_dir_q;
  logic [W-1:0] se_port_q;
  logic [W-1:0] se_dir_q;
  logic [7:0] t2_ctrl_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_st_d;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  logic [DATA_W-1:0] rdata_d;
  logic wr_if_mode;
  logic wr_alt_sel;
  logic wr_pol;
  logic wr_up_port;
  logic wr_up_dir;
  logic wr_se_port;
  logic wr_se_dir;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic wr_t2_ctrl;

  assign wr_if_mode = reg_wr_in && (reg_addr_in == REG_IF_MODE);
  assign wr_alt_sel = reg_wr_in && (reg_addr_in == REG_ALT_SEL);
  assign wr_pol = reg_wr_in && (reg_addr_in == REG_POLARITY);
  assign wr_up_port = reg_wr_in && (reg_addr_in == REG_UP_PORT);
  assign wr_up_dir = reg_wr_in && (reg_addr_in == REG_UP_DIR);
  assign wr_se_port = reg_wr_in && (reg_addr_in == REG_SE_PORT);
  assign wr_se_dir = reg_wr_in && (reg_addr_in == REG_SE_DIR);
  assign wr_irq_clr = reg_wr_in && (reg_addr_in == REG_IRQ_CLR);
  assign wr_irq_en = reg_wr_in && (reg_addr_in == REG_IRQ_EN);
  assign wr_t2_ctrl = reg_wr_in && (reg_addr_in == REG_T2_CTRL);

  assign rdata_d = !reg_rd_in ? RST_VAL :
    (reg_addr_in == REG_IF_MODE) ? if_mode_q :
    (reg_addr_in == REG_ALT_SEL) ? alt_sel_q :
    (reg_addr_in == REG_POLARITY) ? pol_q :
    (reg_addr_in == REG_UP_PORT) ? up_port_q :
    (reg_addr_in == REG_UP_DIR) ? up_dir_q :
    (reg_addr_in == REG_SE_PORT) ? se_port_q :
    (reg_addr_in == REG_SE_DIR) ? se_dir_q :
    (reg_addr_in == REG_UP_PINS) ? upper_port_bit_in :
    (reg_addr_in == REG_SE_PINS) ? second_port_bit_in :
    (reg_addr_in == REG_IRQ_STAT) ? {{(DATA_W-IRQ_W){1'b0}}, irq_st_q} :
    (reg_addr_in == REG_IRQ_EN) ? {{(DATA_W-IRQ_W){1'b0}}, irq_en_q} :
    (reg_addr_in == REG_T2_CTRL) ? t2_ctrl_q : RST_VAL;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      if_mode_q <= RST_VAL;
      alt_sel_q <= RST_VAL;
      pol_q <= RST_VAL;
      up_port_q <= RST_VAL;
      up_dir_q <= RST_VAL;
      se_port_q <= RST_VAL;
      se_dir_q <= RST_VAL;
      t2_ctrl_q <= RST_VAL;
      irq_en_q <= '0;
    end else begin
      if (wr_if_mode) if_mode_q <= reg_wdata_in;
      if (wr_alt_sel) alt_sel_q <= reg_wdata_in;
      if (wr_pol) pol_q <= reg_wdata_in;
      if (wr_up_port) up_port_q <= reg_wdata_in;
      if (wr_up_dir) up_dir_q <= reg_wdata_in;
      if (wr_se_port) se_port_q <= reg_wdata_in;
      if (wr_se_dir) se_dir_q <= reg_wdata_in;
      if (wr_t2_ctrl) t2_ctrl_q <= reg_wdata_in;
      if (wr_irq_en) irq_en_q <= reg_wdata_in[IRQ_W-1:0];
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  logic ext_irq_six_input_rise;
  logic timer2_external_reload_fall;

  assign irq_clr = wr_irq_clr ? reg_wdata_in[IRQ_W-1:0] : '0;
  assign irq_ev = {timer2_ovf_in & alt_sel_q[ALT_T2], timer2_external_reload_fall, ext_irq_six_input_rise};
  assign irq_st_d = (irq_st_q & ~irq_clr) | irq_ev;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_st_q <= '0;
      irq_out <= 1'b0;
      reg_rdata_out <= RST_VAL;
    end else begin
      irq_st_q <= irq_st_d;
      irq_out <= |(irq_st_q & irq_en_q);
      reg_rdata_out <= rdata_d;
    end
  end

  // ****************************************
  // Cpu clock output divider
  // ****************************************
  localparam int CNT_W = $clog2(CLK_DIV + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CLK_DIV - 1);
  logic [CNT_W-1:0] div_cnt_q;
  logic div_wrap;

  assign div_wrap = (div_cnt_q == CNT_LAST);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt_q <= '0;
      cpu_clock_tick_out <= 1'b0;
    end else begin
      div_cnt_q <= div_wrap ? '0 : div_cnt_q + 1'b1;
      cpu_clock_tick_out <= div_wrap;
    end
  end

  // ****************************************
  // Timer overflow stretchers
  // ****************************************
  pdm_ovf_if t0_if ();
  pdm_ovf_if t1_if ();

  assign t0_if.ovf = timer0_ovf_in;
  assign t0_if.low_ovf = timer0_low_ovf_in;
  assign t0_if.split = timer0_split_in;
  assign t0_if.tick = div_wrap;
  assign t1_if.ovf = timer1_ovf_in;
  assign t1_if.low_ovf = timer1_low_ovf_in;
  assign t1_if.split = timer1_split_in;
  assign t1_if.tick = div_wrap;

  pdm_ovf_pulse u_t0_pulse (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .ovf_io(t0_if.gen)
  );

  pdm_ovf_pulse u_t1_pulse (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .ovf_io(t1_if.gen)
  );

  // ****************************************
  // Second port pins
  // ****************************************
  logic [W-1:0] alt_val;
  logic [W-1:0] se_out_d;
  logic [W-1:0] se_oe_n_d;
  logic ser0_val;
  logic ser1_val;
  logic ext_irq_six_input_prev_q;
  logic timer2_external_reload_prev_q;

  assign ser0_val = (serial0_mode_in == SER_SYNC_MODE) ? serial0_data_in : 1'b1;
  assign ser1_val = (serial1_mode_in == SER_SYNC_MODE) ? serial1_data_in : 1'b1;
  assign alt_val = {waveform_addr_bit8_in, 2'b00, ser1_val, ser0_val,
    timer2_ovf_in, t1_if.pulse, t0_if.pulse};
  assign se_out_d = (alt_sel_q & alt_val) | (~alt_sel_q & se_port_q);
  assign se_oe_n_d = (alt_sel_q & ~ALT_DRIVES) | (~alt_sel_q & ~se_dir_q);
  assign ext_irq_six_input_rise = alt_sel_q[ALT_EXT_IRQ_SIX_INPUT] & second_port_bit_in[ALT_EXT_IRQ_SIX_INPUT] & ~ext_irq_six_input_prev_q;
  assign timer2_external_reload_fall = alt_sel_q[ALT_TIMER2_EXTERNAL_RELOAD] & t2_ctrl_q[T2C_EXT_EN_BIT]
    & ~second_port_bit_in[ALT_TIMER2_EXTERNAL_RELOAD] & timer2_external_reload_prev_q;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      second_port_bit_out <= '0;
      second_port_bit_oe_n_out <= '1;
      ext_irq_six_input_prev_q <= 1'b1;
      timer2_external_reload_prev_q <= 1'b0;
      ext_irq_six_out <= 1'b0;
      timer2_external_reload_out <= 1'b0;
    end else begin
      second_port_bit_out <= se_out_d;
      second_port_bit_oe_n_out <= se_oe_n_d;
      ext_irq_six_input_prev_q <= alt_sel_q[ALT_EXT_IRQ_SIX_INPUT] ? second_port_bit_in[ALT_EXT_IRQ_SIX_INPUT] : 1'b1;
      timer2_external_reload_prev_q <= alt_sel_q[ALT_TIMER2_EXTERNAL_RELOAD] ? second_port_bit_in[ALT_TIMER2_EXTERNAL_RELOAD] : 1'b0;
      ext_irq_six_out <= ext_irq_six_input_rise;
      timer2_external_reload_out <= timer2_external_reload_fall;
    end
  end

  // ****************************************
  // Upper port pins
  // ****************************************
  logic wide_bus;
  logic [1:0] if_mode;

  assign if_mode = if_mode_q[1:0];
  assign wide_bus = if_mode[1] & if_mode_q[IFM_WORD_BIT];

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      upper_port_bit_out <= '0;
      upper_port_bit_oe_n_out <= '1;
      parallel_data_bus_hi_out <= '0;
    end else begin
      upper_port_bit_out <= wide_bus ? parallel_data_bus_hi_in : up_port_q;
      upper_port_bit_oe_n_out <= wide_bus ? {W{~parallel_data_bus_drive_in}} : ~up_dir_q;
      parallel_data_bus_hi_out <= wide_bus ? upper_port_bit_in : '0;
    end
  end

  // ****************************************
  // Ready pins and slave strobes
  // ****************************************
  logic slave_mode;
  logic wave_mode;
  logic rd_active;
  logic wr_active;

  assign slave_mode = (if_mode == MODE_SLAVE);
  assign wave_mode = (if_mode == MODE_WAVE);
  assign rd_active = (ready_input_zero_in == pol_q[POL_RD_BIT]);
  assign wr_active = (ready_input_one_in == pol_q[POL_WR_BIT]);

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      waveform_ready_out <= '0;
      slave_read_strobe_out <= 1'b0;
      slave_write_strobe_out <= 1'b0;
      interface_clock_invert_out <= 1'b0;
    end else begin
      waveform_ready_out[0] <= wave_mode & ready_input_zero_in;
      waveform_ready_out[1] <= wave_mode & ready_input_one_in;
      waveform_ready_out[2] <= ready_input_two_in;
      slave_read_strobe_out <= slave_mode & rd_active;
      slave_write_strobe_out <= slave_mode & wr_active;
      interface_clock_invert_out <= if_mode_q[IFM_CLKINV_BIT];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);

  AST_UPPER_BUS: assert property (wide_bus |=>
    upper_port_bit_out == $past(parallel_data_bus_hi_in))
    else $error("upper pins do not follow data bus");
  AST_UPPER_PORT: assert property ((!wide_bus && !wr_up_port) ##1 !wide_bus |->
    upper_port_bit_out == $past(up_port_q))
    else $error("upper pins do not follow port value");
  AST_SE_UNSEL: assert property (!alt_sel_q[ALT_T0] |=>
    second_port_bit_out[ALT_T0] == $past(se_port_q[ALT_T0]))
    else $error("unselected pin shows alternate output");
  AST_T2_PULSE: assert property ((alt_sel_q[ALT_T2] && timer2_ovf_in) ##1
    (alt_sel_q[ALT_T2] && !timer2_ovf_in) |-> second_port_bit_out[ALT_T2] ##1
    !second_port_bit_out[ALT_T2])
    else $error("timer 2 pulse not one cycle");
  AST_SER0_IDLE: assert property ((alt_sel_q[ALT_SER0] && serial0_mode_in != SER_SYNC_MODE)
    |=> second_port_bit_out[ALT_SER0])
    else $error("serial 0 pin not high outside sync mode");
  AST_SER1_IDLE: assert property ((alt_sel_q[ALT_SER1] && serial1_mode_in != SER_SYNC_MODE)
    |=> second_port_bit_out[ALT_SER1])
    else $error("serial 1 pin not high outside sync mode");
  AST_EXT_IRQ_SIX_INPUT_EDGE: assert property ((alt_sel_q[ALT_EXT_IRQ_SIX_INPUT] && !second_port_bit_in[ALT_EXT_IRQ_SIX_INPUT])
    ##1 (alt_sel_q[ALT_EXT_IRQ_SIX_INPUT] && second_port_bit_in[ALT_EXT_IRQ_SIX_INPUT]) |=> ext_irq_six_out ##1
    irq_st_q[IRQ_EXT_IRQ_SIX_INPUT])
    else $error("interrupt six rising edge missed");
  AST_TIMER2_EXTERNAL_RELOAD_GATE: assert property (timer2_external_reload_out |->
    $past(t2_ctrl_q[T2C_EXT_EN_BIT]) && $past(alt_sel_q[ALT_TIMER2_EXTERNAL_RELOAD]) &&
    !$past(second_port_bit_in[ALT_TIMER2_EXTERNAL_RELOAD]))
    else $error("timer 2 reload without falling edge or enable");
  AST_ADR8: assert property (alt_sel_q[ALT_ADR8] |=>
    second_port_bit_out[ALT_ADR8] == $past(waveform_addr_bit8_in) &&
    !second_port_bit_oe_n_out[ALT_ADR8])
    else $error("address bit 8 not on top pin");
  AST_SLAVE_READ_STROBE: assert property (slave_mode && ready_input_zero_in == pol_q[POL_RD_BIT] |=>
    slave_read_strobe_out && !waveform_ready_out[0])
    else $error("read strobe polarity wrong");
  AST_READY_INPUT_TWO: assert property ($past(arst_n_in) |-> waveform_ready_out[2] == $past(ready_input_two_in))
    else $error("ready two not sampled");
  AST_IRQ_SET_WINS: assert property ((irq_ev[IRQ_EXT_IRQ_SIX_INPUT] && irq_clr[IRQ_EXT_IRQ_SIX_INPUT]) |=>
    irq_st_q[IRQ_EXT_IRQ_SIX_INPUT])
    else $error("event lost against clear");

  COV_T0_PULSE: cover property (alt_sel_q[ALT_T0] ##1 $rose(second_port_bit_out[ALT_T0]));
  COV_SLAVE_WR: cover property (slave_mode ##1 slave_write_strobe_out);
  COV_TIMER2_EXTERNAL_RELOAD: cover property (timer2_external_reload_out);
  COV_WIDE: cover property (wide_bus && parallel_data_bus_drive_in);
endmodule : pdm_pin_mux

// File: tb/pdm_board_model.sv
// Board logic model sitting on the multiplexed pins
`timescale 1ns/1ps
module pdm_board_model (
  input wire logic [7:0] up_out_in,
  input wire logic [7:0] up_oe_n_in,
  input wire logic [7:0] se_out_in,
  input wire logic [7:0] se_oe_n_in,
  input wire logic [7:0] up_ext_in,
  input wire logic [7:0] se_ext_in,
  input wire logic [1:0] req_in,
  input wire logic [1:0] pol_in,
  output logic [7:0] up_pin_out,
  output logic [7:0] se_pin_out,
  output logic [1:0] strobe_pin_out
);
  // Device level where its driver is on, board level elsewhere
  assign up_pin_out = (up_out_in & ~up_oe_n_in) | (up_ext_in & up_oe_n_in);
  assign se_pin_out = (se_out_in & ~se_oe_n_in) | (se_ext_in & se_oe_n_in);
  // Master strobes at the configured active level
  assign strobe_pin_out = ~(req_in ^ pol_in);
endmodule : pdm_board_model

// File: tb/testbench.sv
// Self-checking bench for the pin multiplexer
`timescale 1ns/1ps
module testbench import pdm_pkg::*;;
  // ********
  // Signals
  // ********
  localparam int DIV = 2;
  typedef struct packed {
    logic [7:0] mode, alt, dir, port;
    logic [1:0] s0, s1;
    logic [7:0] uoe, uout, soe, sout;
  } pdm_row_t;
  pdm_row_t rows [5] = '{
    '{8'h00, 8'h00, 8'hf0, 8'h5a, 2'h0, 2'h0, 8'h0f, 8'h50, 8'h0f, 8'h50},
    '{8'h06, 8'h00, 8'h0f, 8'h3c, 2'h0, 2'h0, 8'h00, 8'ha5, 8'hf0, 8'h0c},
    '{8'h02, 8'hff, 8'h00, 8'hff, 2'h0, 2'h1, 8'hff, 8'h00, 8'h60, 8'h90},
    '{8'h07, 8'h98, 8'h07, 8'hff, 2'h2, 2'h0, 8'h00, 8'ha5, 8'h60, 8'h8f},
    '{8'h04, 8'h60, 8'h0c, 8'h0c, 2'h3, 2'h3, 8'hf3, 8'h0c, 8'hf3, 8'h0c}};
  logic clk_sys_in = 0, arst_n_in = 0, wr = 0, rd = 0, r2_pin = 0;
  logic [7:0] addr = 0, wdata = 0, up_ext = 0, se_ext = 0;
  logic [7:0] rdata, up_pin, up_out, up_oe, se_pin, se_out, se_oe, dbus_o;
  logic [4:0] ovf = 0;
  logic [1:0] split = 0, s0m = 0, s1m = 0, req = 0, pol = 0, strb;
  logic irq, irq6, rld, inv, tick, srd, swr;
  logic [2:0] wrdy;
  int error_cnt = 0, n_checks = 0, cyc = 0, n_irq6 = 0, n_rld = 0, n_tick = 0;
  pdm_pin_mux #(.CLK_DIV(DIV)) u_pdm_pin_mux (.clk_sys_in, .arst_n_in,
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .irq_out(irq), .upper_port_bit_in(up_pin),
    .upper_port_bit_out(up_out), .upper_port_bit_oe_n_out(up_oe),
    .second_port_bit_in(se_pin), .second_port_bit_out(se_out),
    .second_port_bit_oe_n_out(se_oe), .parallel_data_bus_hi_in(8'ha5),
    .parallel_data_bus_drive_in(1'b1), .parallel_data_bus_hi_out(dbus_o),
    .timer0_ovf_in(ovf[0]), .timer0_low_ovf_in(ovf[1]), .timer0_split_in(split[0]),
    .timer1_ovf_in(ovf[2]), .timer1_low_ovf_in(ovf[3]), .timer1_split_in(split[1]),
    .timer2_ovf_in(ovf[4]), .serial0_mode_in(s0m), .serial0_data_in(1'b0),
    .serial1_mode_in(s1m), .serial1_data_in(1'b0), .waveform_addr_bit8_in(1'b1),
    .ext_irq_six_out(irq6), .timer2_external_reload_out(rld),
    .ready_input_zero_in(strb[0]), .ready_input_one_in(strb[1]),
    .ready_input_two_in(r2_pin), .waveform_ready_out(wrdy),
    .slave_read_strobe_out(srd), .slave_write_strobe_out(swr),
    .interface_clock_invert_out(inv), .cpu_clock_tick_out(tick));
  pdm_board_model u_pdm_board_model (.up_out_in(up_out), .up_oe_n_in(up_oe),
    .se_out_in(se_out), .se_oe_n_in(se_oe), .up_ext_in(up_ext), .se_ext_in(se_ext),
    .req_in(req), .pol_in(pol), .up_pin_out(up_pin), .se_pin_out(se_pin),
    .strobe_pin_out(strb));
  // ********
  // Tasks
  // ********
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : settle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string m);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
    chk(rdata, e, m);
  endtask : rd_chk
  task automatic cnt_pulse(input int sel, input int b, input int e);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    ovf <= 5'h1 << sel;
    @(posedge clk_sys_in);
    ovf <= 5'h0;
    repeat (12) begin
      #1;
      if (se_out[b] === 1'b1) n++;
      @(posedge clk_sys_in);
    end
    chk(n[7:0], e[7:0], "pulse width");
  endtask : cnt_pulse
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (irq6 === 1'b1) n_irq6++;
    if (rld === 1'b1) n_rld++;
    if (tick === 1'b1) n_tick++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[ERR] %0t run timed out", $time);
      stop_test();
    end
  end
  // ********
  // Sequence
  // ********
  initial begin
    repeat (16) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    settle(1);
    chk(up_oe & se_oe, 8'hff, "reset oe");
    chk(up_out | se_out | dbus_o, 8'h00, "reset out");
    for (int a = 0; a < 14; a++) rd_chk(a[7:0], 8'h00, "reset reg");
    wr_reg(8'h3f, 8'hff);
    rd_chk(8'h3f, 8'h00, "unmapped");
    $display("reset test done");
    @(posedge clk_sys_in) up_ext <= 8'h3c;
    foreach (rows[i]) begin
      wr_reg(REG_IF_MODE, rows[i].mode);
      wr_reg(REG_ALT_SEL, rows[i].alt);
      wr_reg(REG_UP_DIR, rows[i].dir);
      wr_reg(REG_SE_DIR, rows[i].dir);
      wr_reg(REG_UP_PORT, rows[i].port);
      wr_reg(REG_SE_PORT, rows[i].port);
      s0m <= rows[i].s0;
      s1m <= rows[i].s1;
      settle(3);
      chk(up_oe, rows[i].uoe, "up oe");
      chk(up_out & ~up_oe, rows[i].uout, "up out");
      chk(dbus_o, (rows[i].mode[1] & rows[i].mode[2]) ? 8'ha5 : 8'h00, "bus");
      chk(se_oe, rows[i].soe, "se oe");
      chk(se_out & ~se_oe, rows[i].sout, "se out");
      rd_chk(REG_UP_PINS, rows[i].uout | (8'h3c & rows[i].uoe), "up pins");
      rd_chk(REG_SE_PINS, rows[i].sout, "se pins");
      rd_chk(REG_ALT_SEL, rows[i].alt, "alt back");
      $display("row %0d done", i);
    end
    wr_reg(REG_ALT_SEL, 8'h07);
    cnt_pulse(0, 0, DIV);
    cnt_pulse(2, 1, DIV);
    cnt_pulse(4, 2, 1);
    split <= 2'h3;
    cnt_pulse(1, 0, DIV);
    cnt_pulse(0, 0, 0);
    cnt_pulse(3, 1, DIV);
    split <= 2'h0;
    wr_reg(REG_ALT_SEL, 8'h00);
    cnt_pulse(0, 0, 0);
    #1;
    n_tick = 0;
    settle(20);
    chk(n_tick[7:0], 8'(20 / DIV), "tick count");
    $display("timer test done");
    wr_reg(REG_SE_DIR, 8'h00);
    wr_reg(REG_IRQ_CLR, 8'h07);
    wr_reg(REG_IRQ_EN, 8'h07);
    wr_reg(REG_ALT_SEL, 8'h60);
    @(posedge clk_sys_in) se_ext <= 8'h20;
    settle(4);
    chk(n_irq6[7:0], 8'h01, "rise");
    chk({7'h0, irq}, 8'h01, "irq on");
    rd_chk(REG_IRQ_STAT, 8'h01, "stat");
    @(posedge clk_sys_in) se_ext <= 8'h00;
    settle(4);
    chk(n_irq6[7:0], 8'h01, "fall");
    wr_reg(REG_IRQ_CLR, 8'h01);
    settle(2);
    chk({7'h0, irq}, 8'h00, "irq clr");
    rd_chk(REG_IRQ_CLR, 8'h00, "clr read");
    wr_reg(REG_IRQ_EN, 8'h00);
    @(posedge clk_sys_in);
    se_ext <= 8'h20;
    addr <= REG_IRQ_CLR;
    wdata <= 8'h01;
    wr <= 1'b1;
    @(posedge clk_sys_in) wr <= 1'b0;
    settle(4);
    chk({7'h0, irq}, 8'h00, "masked");
    rd_chk(REG_IRQ_STAT, 8'h01, "stat masked");
    wr_reg(REG_IRQ_CLR, 8'h07);
    wr_reg(REG_ALT_SEL, 8'h00);
    @(posedge clk_sys_in) se_ext <= 8'h00;
    settle(3);
    @(posedge clk_sys_in) se_ext <= 8'h20;
    settle(4);
    chk(n_irq6[7:0], 8'h02, "unselected");
    wr_reg(REG_ALT_SEL, 8'h40);
    for (int en = 0; en < 2; en++) begin
      wr_reg(REG_T2_CTRL, en[0] ? 8'h08 : 8'h00);
      @(posedge clk_sys_in) se_ext <= 8'h40;
      settle(3);
      @(posedge clk_sys_in) se_ext <= 8'h00;
      settle(4);
      chk(n_rld[7:0], en[7:0], "reload");
    end
    rd_chk(REG_IRQ_STAT, 8'h02, "reload stat");
    $display("input test done");
    wr_reg(REG_IF_MODE, 8'h03);
    for (int p = 0; p < 4; p++) begin
      wr_reg(REG_POLARITY, {4'h0, p[0], p[1], 2'h0});
      pol <= p[1:0];
      for (int r = 0; r < 4; r++) begin
        @(posedge clk_sys_in) req <= r[1:0];
        settle(2);
        chk({6'h0, swr, srd}, {6'h0, r[1:0]}, "strobe");
      end
    end
    @(posedge clk_sys_in) r2_pin <= 1'b1;
    settle(2);
    chk({5'h0, wrdy}, 8'h04, "ready two");
    wr_reg(REG_IF_MODE, 8'h02);
    settle(2);
    chk({5'h0, wrdy}, 8'h07, "ready in");
    chk({6'h0, swr, srd}, 8'h00, "no strobe");
    for (int v = 0; v < 2; v++) begin
      wr_reg(REG_IF_MODE, v[0] ? 8'h08 : 8'h00);
      settle(2);
      chk({7'h0, inv}, v[7:0], "clk invert");
    end
    $display("interface test done");
    wr_reg(REG_UP_DIR, 8'hff);
    @(posedge clk_sys_in) arst_n_in <= 1'b0;
    settle(2);
    chk(up_oe & se_oe, 8'hff, "mid reset");
    @(posedge clk_sys_in) arst_n_in <= 1'b1;
    settle(2);
    chk(up_oe, 8'hff, "after reset");
    $display("second reset test done");
    stop_test();
  end
endmodule : testbench
